// *** mcc_pkg.sv ***
// What this block does
// (RL1) outside virt_ext: undefined_opcode_fault first
// (RL2) guest mode: exit to guest monitor only
// (RL3) guest exit records monitor-call exit reason
// (RL4) root in sys_mgmt_mode or invalid control: fail
// (RL5) v86 or long mode without CS.L: fault
// (RL6) privilege above zero: protection fault, code zero
// (RL7) dual monitor active: sys_mgmt_mode exit
// (RL8) no valid structure pointer: fail without structure
// (RL9) launch state not clear: fail with structure
// (RL10) bad state-saving exit controls: fail with structure
// (RL11) enter mode, check revision, mismatch fails
// (RL12) check features: fail or activate dual monitor
// (RL13) decode opcode 0F 01 C1
// (RL14) lock, repeat, operand-size prefix fault
// (RL15) real-address mode always faults
// (RL16) exactly one one-hot outcome per call taken while idle; a call while busy gets none
`default_nettype none
package mcc_pkg;
  // ----------------------------------------
  // register map, byte addresses
  // ----------------------------------------
  localparam logic [4:0] REG_REV = 5'h00;
  localparam logic [4:0] REG_STATUS = 5'h04;
  localparam logic [4:0] REG_MASK = 5'h08;
  localparam logic [4:0] REG_RESULT = 5'h0C;
  localparam logic [4:0] REG_DUAL = 5'h10;
  localparam logic [31:0] REV_RESET = 32'h00000001;
  localparam logic [6:0] MASK_RESET = 7'h00;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  // ----------------------------------------
  // outcome bits and fields
  // ----------------------------------------
  localparam int NOUT = 7;
  localparam int OUT_UD = 0;
  localparam int OUT_GP = 1;
  localparam int OUT_GUEST = 2;
  localparam int OUT_FAILINV = 3;
  localparam int OUT_FAILVAL = 4;
  localparam int OUT_SMMEXIT = 5;
  localparam int OUT_DUAL = 6;
  localparam int RES_ERR_LSB = 8;
  localparam int RES_BUSY = 16;
  localparam int RES_SMM = 17;
  localparam logic [23:0] OPC_MONCALL = 24'h0F01C1;
  localparam logic [7:0] ERR_NONE = 8'h00;
  localparam logic [7:0] ERR_ROOT = 8'h01;
  localparam logic [7:0] ERR_NONCLEAR = 8'h02;
  localparam logic [7:0] ERR_EXITCTL = 8'h03;
  localparam logic [7:0] ERR_REV = 8'h04;
  localparam logic [7:0] ERR_FEAT = 8'h05;
endpackage
`default_nettype wire

// *** mcc_decide.sv ***
`default_nettype none
module mcc_decide
  import mcc_pkg::*;
(
  input wire logic [23:0] opcode, // instruction bytes
  input wire logic lockPfx, // lock prefix seen
  input wire logic repPfx, // any repeat prefix
  input wire logic opSizePfx, // operand-size prefix
  input wire logic realMode, // real-address mode
  input wire logic inVirtExt, // in virt_ext operation
  input wire logic nonRoot, // guest operation
  input wire logic sysMgmtMode, // core in sys_mgmt_mode
  input wire logic smmMonCtlValid, // monitor control valid bit
  input wire logic v86Flag, // v86 flag
  input wire logic longModeActive, // long mode active
  input wire logic csLong, // code segment long bit
  input wire logic [1:0] curPrivLevel, // privilege level
  input wire logic dualActive, // dual monitor treatment on
  input wire logic vmcsPtrValid, // structure pointer valid
  input wire logic launchClear, // launch state clear
  input wire logic exitCtlValid, // save exit controls valid
  output logic isCall, // opcode matches
  output logic [NOUT-1:0] outcome, // immediate outcome, one-hot; all zero when startAct
  output logic [7:0] failErr, // error number for failures
  output logic startAct // go to the activation steps
);
  always_comb begin
    isCall = (opcode == OPC_MONCALL); // RL13
    outcome = '0;
    failErr = ERR_NONE;
    startAct = 1'b0;
    // decode-time faults outrank every state check
    if (lockPfx || repPfx || opSizePfx) begin
      outcome[OUT_UD] = 1'b1; // RL14
    end else if (realMode || !inVirtExt) begin
      outcome[OUT_UD] = 1'b1; // RL1 RL15
    end else if (nonRoot) begin
      outcome[OUT_GUEST] = 1'b1; // RL2
    end else if (sysMgmtMode || !smmMonCtlValid) begin
      failErr = ERR_ROOT; // RL4
      if (vmcsPtrValid) begin
        outcome[OUT_FAILVAL] = 1'b1;
      end else begin
        outcome[OUT_FAILINV] = 1'b1;
      end
    end else if (v86Flag || (longModeActive && !csLong)) begin
      outcome[OUT_UD] = 1'b1; // RL5
    end else if (curPrivLevel != 2'h0) begin
      outcome[OUT_GP] = 1'b1; // RL6
    end else if (dualActive) begin
      outcome[OUT_SMMEXIT] = 1'b1; // RL7
    end else if (!vmcsPtrValid) begin
      outcome[OUT_FAILINV] = 1'b1; // RL8
    end else if (!launchClear) begin
      outcome[OUT_FAILVAL] = 1'b1; // RL9
      failErr = ERR_NONCLEAR;
    end else if (!exitCtlValid) begin
      outcome[OUT_FAILVAL] = 1'b1; // RL10
      failErr = ERR_EXITCTL;
    end else begin
      startAct = 1'b1; // RL11
    end
  end
endmodule
`default_nettype wire

// *** mcc_unit.sv ***
// Local design decisions: the register offsets and the AXI4-Lite slave port.
`default_nettype none
module mcc_unit
  import mcc_pkg::*;
#(
  parameter logic [15:0] EXIT_REASON = 16'h0001
)(
  input wire logic ref_clk, // core clock
  input wire logic rst, // async reset, high
  input wire logic instrValid, // one-cycle execute strobe
  input wire logic [23:0] opcode, // instruction bytes
  input wire logic lockPfx, // lock prefix
  input wire logic repPfx, // repeat prefix
  input wire logic opSizePfx, // operand-size prefix
  input wire logic realMode, // real-address mode
  input wire logic inVirtExt, // in virt_ext operation
  input wire logic nonRoot, // guest operation
  input wire logic sysMgmtMode, // core in sys_mgmt_mode
  input wire logic smmMonCtlValid, // monitor control valid bit
  input wire logic v86Flag, // v86 flag
  input wire logic longModeActive, // long mode active
  input wire logic csLong, // code segment long bit
  input wire logic [1:0] curPrivLevel, // privilege level
  input wire logic vmcsPtrValid, // structure pointer valid
  input wire logic launchClear, // launch state clear
  input wire logic exitCtlValid, // save exit controls valid
  input wire logic [31:0] monSegRev, // monitor_segment revision
  input wire logic featuresValid, // monitor_segment features ok
  output logic resultValid, // one-cycle outcome pulse
  output logic [NOUT-1:0] result, // one-hot outcome
  output logic [7:0] failErr, // failure error number
  output logic [15:0] exitReason, // reason on guest exit
  output logic [15:0] errCode, // protection fault code
  output logic smmActive, // block holds sys_mgmt_mode
  output logic dualActive, // dual monitor treatment on
  output logic busy, // activation steps running
  output logic irq, // level interrupt
  input wire logic [4:0] s_axi_awaddr, // write address
  input wire logic s_axi_awvalid, // write address valid
  output logic s_axi_awready, // write address ready
  input wire logic [31:0] s_axi_wdata, // write data
  input wire logic [3:0] s_axi_wstrb, // byte strobes
  input wire logic s_axi_wvalid, // write data valid
  output logic s_axi_wready, // write data ready
  output logic [1:0] s_axi_bresp, // write response
  output logic s_axi_bvalid, // write response valid
  input wire logic s_axi_bready, // write response ready
  input wire logic [4:0] s_axi_araddr, // read address
  input wire logic s_axi_arvalid, // read address valid
  output logic s_axi_arready, // read address ready
  output logic [31:0] s_axi_rdata, // read data
  output logic [1:0] s_axi_rresp, // read response
  output logic s_axi_rvalid, // read data valid
  input wire logic s_axi_rready // read data ready
);
  // ----------------------------------------
  // state
  // ----------------------------------------
  typedef enum logic [2:0] {
    S_IDLE = 3'b001,
    S_REV = 3'b010,
    S_FEAT = 3'b100
  } mcc_st_t;

  typedef struct packed {
    mcc_st_t st;
    logic resV;
    logic [NOUT-1:0] res;
    logic [7:0] err;
    logic [15:0] reason;
    logic [15:0] ecode;
    logic sys_mgmt_mode;
    logic dual;
    logic busy;
    logic irq;
    logic [31:0] rev;
    logic [NOUT-1:0] sts;
    logic [NOUT-1:0] msk;
    logic awRdy;
    logic wRdy;
    logic awHeld;
    logic wHeld;
    logic [4:0] awA;
    logic [31:0] wD;
    logic [3:0] wS;
    logic bV;
    logic [1:0] bR;
    logic arRdy;
    logic rV;
    logic [31:0] rD;
    logic [1:0] rR;
  } mcc_state_t;

  mcc_state_t q;
  mcc_state_t n;
  logic isCall;
  logic [NOUT-1:0] decOut;
  logic [7:0] decErr;
  logic startAct;

  mcc_decide u_decide (
    .opcode(opcode),
    .lockPfx(lockPfx),
    .repPfx(repPfx),
    .opSizePfx(opSizePfx),
    .realMode(realMode),
    .inVirtExt(inVirtExt),
    .nonRoot(nonRoot),
    .sysMgmtMode(sysMgmtMode),
    .smmMonCtlValid(smmMonCtlValid),
    .v86Flag(v86Flag),
    .longModeActive(longModeActive),
    .csLong(csLong),
    .curPrivLevel(curPrivLevel),
    .dualActive(q.dual),
    .vmcsPtrValid(vmcsPtrValid),
    .launchClear(launchClear),
    .exitCtlValid(exitCtlValid),
    .isCall(isCall),
    .outcome(decOut),
    .failErr(decErr),
    .startAct(startAct)
  );

  // ----------------------------------------
  // next state
  // ----------------------------------------
  always_comb begin
    n = q;
    n.resV = 1'b0;
    n.res = '0;
    // ---- outcome sequencing ----
    unique case (q.st)
      S_IDLE: begin
        // a call during activation steps is not taken; busy tells the core
        if (instrValid && isCall) begin
          if (startAct) begin
            n.st = S_REV; // RL11
            n.sys_mgmt_mode = 1'b1;
          end else begin
            n.resV = 1'b1; // RL16
            n.res = decOut;
            n.err = decErr;
            n.ecode = 16'h0000; // RL6
            if (decOut[OUT_GUEST]) begin
              n.reason = EXIT_REASON; // RL3
            end
          end
        end
      end
      S_REV: begin
        if (monSegRev != q.rev) begin
          n.st = S_IDLE; // RL11
          n.sys_mgmt_mode = 1'b0;
          n.resV = 1'b1;
          n.res[OUT_FAILVAL] = 1'b1;
          n.err = ERR_REV;
        end else begin
          n.st = S_FEAT;
        end
      end
      S_FEAT: begin
        n.st = S_IDLE;
        n.resV = 1'b1;
        if (!featuresValid) begin
          n.sys_mgmt_mode = 1'b0; // RL12
          n.res[OUT_FAILVAL] = 1'b1;
          n.err = ERR_FEAT;
        end else begin
          n.dual = 1'b1; // RL12
          n.res[OUT_DUAL] = 1'b1;
          n.err = ERR_NONE;
        end
      end
      default: begin
        n.st = S_IDLE;
        n.sys_mgmt_mode = 1'b0;
      end
    endcase
    n.busy = (n.st != S_IDLE);
    // ---- bus write ----
    if (q.bV && s_axi_bready) begin
      n.bV = 1'b0;
    end
    if (s_axi_awvalid && q.awRdy) begin
      n.awHeld = 1'b1;
      n.awA = s_axi_awaddr;
    end
    if (s_axi_wvalid && q.wRdy) begin
      n.wHeld = 1'b1;
      n.wD = s_axi_wdata;
      n.wS = s_axi_wstrb;
    end
    if (q.awHeld && q.wHeld && !q.bV) begin
      n.awHeld = 1'b0;
      n.wHeld = 1'b0;
      n.bV = 1'b1;
      n.bR = RESP_OKAY;
      unique case (q.awA)
        REG_REV: begin
          for (int i = 0; i < 4; i++) begin
            if (q.wS[i]) begin
              n.rev[i*8 +: 8] = q.wD[i*8 +: 8];
            end
          end
        end
        REG_MASK: begin
          if (q.wS[0]) begin
            n.msk = q.wD[NOUT-1:0];
          end
        end
        REG_DUAL: begin
          // hardware activation in the same cycle wins over software
          if (q.wS[0] && !(q.st == S_FEAT && featuresValid)) begin
            n.dual = q.wD[0];
          end
        end
        REG_STATUS, REG_RESULT: begin
          n.bR = RESP_OKAY;
        end
        default: begin
          n.bR = RESP_SLVERR;
        end
      endcase
    end
    n.awRdy = !n.awHeld && !n.bV;
    n.wRdy = !n.wHeld && !n.bV;
    // ---- bus read ----
    if (q.rV && s_axi_rready) begin
      n.rV = 1'b0;
    end
    if (s_axi_arvalid && q.arRdy) begin
      n.rV = 1'b1;
      n.rR = RESP_OKAY;
      n.rD = '0;
      unique case (s_axi_araddr)
        REG_REV: n.rD = q.rev;
        REG_STATUS: begin
          n.rD[NOUT-1:0] = q.sts;
          n.sts = '0;
        end
        REG_MASK: n.rD[NOUT-1:0] = q.msk;
        REG_RESULT: begin
          n.rD[NOUT-1:0] = q.res;
          n.rD[RES_ERR_LSB +: 8] = q.err;
          n.rD[RES_BUSY] = q.busy;
          n.rD[RES_SMM] = q.sys_mgmt_mode;
        end
        REG_DUAL: n.rD[0] = q.dual;
        default: n.rR = RESP_SLVERR;
      endcase
    end
    n.arRdy = !n.rV;
    // set after clear, so an event in the clearing read survives
    if (n.resV) begin
      n.sts = n.sts | n.res;
    end
    n.irq = |(n.sts & n.msk);
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      q <= '{st: S_IDLE, rev: REV_RESET, msk: MASK_RESET, awRdy: 1'b1,
             wRdy: 1'b1, arRdy: 1'b1, default: '0};
    end else begin
      q <= n;
    end
  end

  // ----------------------------------------
  // outputs
  // ----------------------------------------
  assign resultValid = q.resV;
  assign result = q.res;
  assign failErr = q.err;
  assign exitReason = q.reason;
  assign errCode = q.ecode;
  assign smmActive = q.sys_mgmt_mode;
  assign dualActive = q.dual;
  assign busy = q.busy;
  assign irq = q.irq;
  assign s_axi_awready = q.awRdy;
  assign s_axi_wready = q.wRdy;
  assign s_axi_bresp = q.bR;
  assign s_axi_bvalid = q.bV;
  assign s_axi_arready = q.arRdy;
  assign s_axi_rdata = q.rD;
  assign s_axi_rresp = q.rR;
  assign s_axi_rvalid = q.rV;

  // ----------------------------------------
  // checks
  // ----------------------------------------
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (rst);

  sequence s_take;
    instrValid && opcode == OPC_MONCALL && !busy;
  endsequence

  sequence s_clean;
    !lockPfx && !repPfx && !opSizePfx && !realMode;
  endsequence

  chk_ud_outside: assert property ( // RL1
    s_take and s_clean and !inVirtExt |=> resultValid && result[OUT_UD] && !result[OUT_GP])
    else $error("call outside virt_ext did not fault");

  chk_guest_exit: assert property ( // RL2 RL3
    s_take and s_clean and inVirtExt && nonRoot
    |=> resultValid && result[OUT_GUEST] && exitReason == EXIT_REASON && !smmActive)
    else $error("guest call did not exit with reason");

  chk_root_fail: assert property ( // RL4
    s_take and s_clean and inVirtExt && !nonRoot && !smmMonCtlValid
    |=> resultValid && (result[OUT_FAILVAL] || result[OUT_FAILINV]) && failErr == ERR_ROOT)
    else $error("root call without monitor control did not fail");

  chk_prefix_ud: assert property ( // RL14
    s_take and (lockPfx || opSizePfx) |=> resultValid && result[OUT_UD])
    else $error("bad prefix did not fault");

  chk_gp_code: assert property ( // RL6
    resultValid && result[OUT_GP] |-> errCode == 16'h0000 && $past(curPrivLevel) != 2'h0)
    else $error("protection fault with wrong code or level");

  chk_one_hot: assert property ( // RL16
    resultValid |-> $onehot(result))
    else $error("outcome not one-hot");

  chk_rev_fail: assert property ( // RL11
    $rose(busy) && monSegRev != q.rev
    |=> resultValid && result[OUT_FAILVAL] && failErr == ERR_REV && !smmActive)
    else $error("revision mismatch not reported");

  chk_activate: assert property ( // RL12
    s_take and s_clean and inVirtExt && !nonRoot && startAct
    |=> smmActive && monSegRev == q.rev ##1 featuresValid
    |=> resultValid && result[OUT_DUAL] && dualActive && smmActive)
    else $error("activation did not complete");

  chk_irq_level: assert property (
    (|(q.sts & q.msk)) |-> irq)
    else $error("interrupt low with unmasked status");
endmodule
`default_nettype wire

// *** mcc_testbench.sv ***
`default_nettype none
module testbench
  import mcc_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  // ----------------------------------------
  // stimulus and observed signals
  // ----------------------------------------
  localparam logic [13:0] BASE = 14'h0247;
  localparam logic [15:0] XR = 16'h00A3; // arbitrary exit reason
  logic ref_clk = 1'b0;
  logic rst = 1'b1;
  logic instrValid = 1'b0;
  logic [23:0] opcode = 24'h000000;
  logic [13:0] flg = BASE;
  logic [1:0] current_priv_level = 2'h0;
  logic [31:0] monSegRev = 32'h00000001;
  logic featuresValid = 1'b0;
  logic resultValid, smmActive, dualActive, busy, irq;
  logic [6:0] result;
  logic [7:0] failErr;
  logic [15:0] exitReason, errCode;
  logic [4:0] awAddr = 5'h00;
  logic [4:0] arAddr = 5'h00;
  logic [31:0] wData = 32'h00000000;
  logic awValid = 1'b0;
  logic wValid = 1'b0;
  logic bReady = 1'b0;
  logic arValid = 1'b0;
  logic rReady = 1'b0;
  logic awReady, wReady, bValid, arReady, rValid;
  logic [1:0] bResp, rResp;
  logic [31:0] rData;
  int fails = 0;
  int check_count = 0;
  int cycles = 0;

  always #2 ref_clk = ~ref_clk;

  mcc_unit #(.EXIT_REASON(XR)) uut (
    .ref_clk(ref_clk), .rst(rst), .instrValid(instrValid), .opcode(opcode),
    .lockPfx(flg[13]), .repPfx(flg[12]), .opSizePfx(flg[11]), .realMode(flg[10]),
    .inVirtExt(flg[9]), .nonRoot(flg[8]), .sysMgmtMode(flg[7]),
    .smmMonCtlValid(flg[6]), .v86Flag(flg[5]), .longModeActive(flg[4]),
    .csLong(flg[3]), .curPrivLevel(current_priv_level), .vmcsPtrValid(flg[2]),
    .launchClear(flg[1]), .exitCtlValid(flg[0]), .monSegRev(monSegRev),
    .featuresValid(featuresValid), .resultValid(resultValid), .result(result),
    .failErr(failErr), .exitReason(exitReason), .errCode(errCode),
    .smmActive(smmActive), .dualActive(dualActive), .busy(busy), .irq(irq),
    .s_axi_awaddr(awAddr), .s_axi_awvalid(awValid), .s_axi_awready(awReady),
    .s_axi_wdata(wData), .s_axi_wstrb(4'hF), .s_axi_wvalid(wValid),
    .s_axi_wready(wReady), .s_axi_bresp(bResp), .s_axi_bvalid(bValid),
    .s_axi_bready(bReady), .s_axi_araddr(arAddr), .s_axi_arvalid(arValid),
    .s_axi_arready(arReady), .s_axi_rdata(rData), .s_axi_rresp(rResp),
    .s_axi_rvalid(rValid), .s_axi_rready(rReady)
  );

  // ----------------------------------------
  // compare, report and bus tasks
  // ----------------------------------------
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", check_count, fails);
    if (fails == 0 && check_count > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      fails++;
      $display("Error at %0t: value %h expected %h", $time, got, exp);
    end
  endtask

  task automatic chk_resp(input logic [1:0] got, input logic [1:0] exp);
    check_count++;
    if (got !== exp) begin
      fails++;
      $display("Error at %0t: response %h expected %h", $time, got, exp);
    end
  endtask

  task automatic tdone(input string s);
    $display("test %s done", s);
  endtask

  // registered outputs read right after the edge still show the sampled value
  task automatic wr(input logic [4:0] a, input logic [31:0] d, input logic [1:0] er);
    int n;
    @(posedge ref_clk);
    awAddr <= a;
    wData <= d;
    awValid <= 1'b1;
    wValid <= 1'b1;
    bReady <= 1'b1;
    for (n = 0; n < 64; n++) begin
      @(posedge ref_clk);
      if (awValid && awReady === 1'b1) awValid <= 1'b0;
      if (wValid && wReady === 1'b1) wValid <= 1'b0;
      if (bValid === 1'b1) break;
    end
    bReady <= 1'b0;
    chk_resp(n < 64 ? bResp : 2'bxx, er);
  endtask

  task automatic rdc(input logic [4:0] a, input logic [31:0] ed, input logic [1:0] er);
    int n;
    @(posedge ref_clk);
    arAddr <= a;
    arValid <= 1'b1;
    rReady <= 1'b1;
    for (n = 0; n < 64; n++) begin
      @(posedge ref_clk);
      if (arValid && arReady === 1'b1) arValid <= 1'b0;
      if (rValid === 1'b1) break;
    end
    rReady <= 1'b0;
    chk_resp(n < 64 ? rResp : 2'bxx, er);
    chk(rData, ed);
  endtask

  // flags are flipped from an all-checks-pass state; b < 0 means no outcome
  task automatic call(input logic [23:0] opc, input logic [13:0] m, input logic [1:0] c,
                      input int b, input logic [7:0] err);
    int n;
    @(posedge ref_clk);
    instrValid <= 1'b1;
    opcode <= opc;
    flg <= BASE ^ m;
    current_priv_level <= c;
    @(posedge ref_clk);
    instrValid <= 1'b0;
    for (n = 0; n < 6 && resultValid !== 1'b1; n++) @(posedge ref_clk);
    chk(32'(result & {7{resultValid}}), b < 0 ? 32'h0 : 32'h1 << b);
    if (b == OUT_FAILVAL || b == OUT_FAILINV) chk(32'(failErr), 32'(err));
  endtask

  // ----------------------------------------
  // watchdog and main sequence
  // ----------------------------------------
  always @(posedge ref_clk) begin
    cycles <= cycles + 1;
    if (cycles == 5000) begin
      fails = fails + 1;
      wrap_up();
    end
  end

  initial begin
    repeat (16) @(posedge ref_clk);
    rst <= 1'b0;
    rdc(REG_REV, REV_RESET, RESP_OKAY);
    rdc(REG_MASK, 32'h0, RESP_OKAY);
    rdc(5'h14, 32'h0, RESP_SLVERR);
    wr(5'h18, 32'h1, RESP_SLVERR);
    tdone("registers");
    call(OPC_MONCALL, 14'h2000, 2'h0, OUT_UD, ERR_NONE);
    call(OPC_MONCALL, 14'h1000, 2'h0, OUT_UD, ERR_NONE);
    call(OPC_MONCALL, 14'h0800, 2'h0, OUT_UD, ERR_NONE);
    call(OPC_MONCALL, 14'h0400, 2'h0, OUT_UD, ERR_NONE);
    call(OPC_MONCALL, 14'h0200, 2'h0, OUT_UD, ERR_NONE);
    call(OPC_MONCALL, 14'h0300, 2'h3, OUT_UD, ERR_NONE);
    call(24'h0F01C2, 14'h0000, 2'h0, -1, ERR_NONE);
    call(OPC_MONCALL, 14'h0100, 2'h3, OUT_GUEST, ERR_NONE);
    chk(32'(exitReason), 32'(XR));
    call(OPC_MONCALL, 14'h0080, 2'h3, OUT_FAILVAL, ERR_ROOT);
    call(OPC_MONCALL, 14'h0044, 2'h0, OUT_FAILINV, ERR_ROOT);
    call(OPC_MONCALL, 14'h0020, 2'h3, OUT_UD, ERR_NONE);
    call(OPC_MONCALL, 14'h0010, 2'h0, OUT_UD, ERR_NONE);
    call(OPC_MONCALL, 14'h0018, 2'h3, OUT_GP, ERR_NONE);
    call(OPC_MONCALL, 14'h0000, 2'h1, OUT_GP, ERR_NONE);
    chk(32'(errCode), 32'h0);
    call(OPC_MONCALL, 14'h0004, 2'h0, OUT_FAILINV, ERR_NONE);
    call(OPC_MONCALL, 14'h0003, 2'h0, OUT_FAILVAL, ERR_NONCLEAR);
    call(OPC_MONCALL, 14'h0001, 2'h0, OUT_FAILVAL, ERR_EXITCTL);
    tdone("priority");
    wr(REG_REV, 32'h000000A5, RESP_OKAY);
    rdc(REG_REV, 32'h000000A5, RESP_OKAY);
    monSegRev <= 32'h000000A4;
    call(OPC_MONCALL, 14'h0000, 2'h0, OUT_FAILVAL, ERR_REV);
    chk(32'(smmActive), 32'h0);
    monSegRev <= 32'h000000A5;
    call(OPC_MONCALL, 14'h0000, 2'h0, OUT_FAILVAL, ERR_FEAT);
    chk(32'(smmActive), 32'h0);
    featuresValid <= 1'b1;
    call(OPC_MONCALL, 14'h0000, 2'h0, OUT_DUAL, ERR_NONE);
    chk(32'(dualActive), 32'h1);
    chk(32'(smmActive), 32'h1);
    call(OPC_MONCALL, 14'h0000, 2'h0, OUT_SMMEXIT, ERR_NONE);
    rdc(REG_DUAL, 32'h1, RESP_OKAY);
    rdc(REG_RESULT, 32'h1 << RES_SMM, RESP_OKAY);
    wr(REG_DUAL, 32'h0, RESP_OKAY);
    repeat (2) @(posedge ref_clk);
    chk(32'(dualActive), 32'h0);
    tdone("activation");
    // status is full but the mask still blocks the interrupt
    chk(32'(irq), 32'h0);
    wr(REG_MASK, 32'h00000040, RESP_OKAY);
    repeat (2) @(posedge ref_clk);
    chk(32'(irq), 32'h1);
    rdc(REG_MASK, 32'h00000040, RESP_OKAY);
    rdc(REG_STATUS, 32'h0000007F, RESP_OKAY);
    repeat (2) @(posedge ref_clk);
    chk(32'(irq), 32'h0);
    rdc(REG_STATUS, 32'h0, RESP_OKAY);
    tdone("interrupt");
    wrap_up();
  end
endmodule
`default_nettype wire
